// ===== hw/cspf_pkg.sv
// shared constants and carriers for the stack pointer, instruction address counter and condition flags block
// assumes the core sequencer runs on the same clock as the register file
package cspf_pkg;
  // register map, byte addresses on a 32-bit avalon-mm word bus
  localparam logic [3:0] CSPF_OFS_SP = 4'h0;
  localparam logic [3:0] CSPF_OFS_PC = 4'h4;
  localparam logic [3:0] CSPF_OFS_FLAGS = 4'h8;
  localparam logic [3:0] CSPF_OFS_STAT = 4'hc;
  // reset values and fixed patterns
  localparam logic [15:0] CSPF_SP_RST = 16'h00ff;
  localparam logic [7:0] CSPF_SP_LOW_RST = 8'hff;
  localparam logic [15:0] CSPF_VEC_HI_ADDR = 16'hfffe;
  localparam logic [15:0] CSPF_VEC_LO_ADDR = 16'hffff;
  localparam logic [7:0] CSPF_FLAGS_RST = 8'h68;
  localparam logic [7:0] CSPF_FLAGS_ONES = 8'h60;
  // condition flag bit positions
  localparam int CSPF_B_V = 7;
  localparam int CSPF_B_H = 4;
  localparam int CSPF_B_I = 3;
  localparam int CSPF_B_N = 2;
  localparam int CSPF_B_Z = 1;
  localparam int CSPF_B_C = 0;
  // decimal adjust figures
  localparam logic [3:0] CSPF_BCD_DIG_MAX = 4'h9;
  localparam logic [7:0] CSPF_BCD_BYTE_MAX = 8'h99;
  localparam logic [7:0] CSPF_BCD_CORR_LO = 8'h06;
  localparam logic [7:0] CSPF_BCD_CORR_HI = 8'h60;
  // stack pointer operations
  typedef enum logic [2:0] {
    CSPF_SP_NONE, CSPF_SP_PUSH, CSPF_SP_PULL, CSPF_SP_ADJ, CSPF_SP_LOWRST, CSPF_SP_LOAD
  } cspf_sp_op_e;
  // condition flag operations
  typedef enum logic [2:0] {
    CSPF_FL_NONE, CSPF_FL_ADD, CSPF_FL_SUB, CSPF_FL_LDST, CSPF_FL_DAA, CSPF_FL_WR, CSPF_FL_MCLR, CSPF_FL_IENT
  } cspf_fl_op_e;
  // one command from the core sequencer, valid for the cycle it is presented
  typedef struct packed {
    logic fetch;
    logic pc_load;
    logic [15:0] pc_target;
    cspf_sp_op_e sp_op;
    logic [15:0] sp_val;
    cspf_fl_op_e fl_op;
    logic [7:0] opa;
    logic [7:0] opb;
    logic use_carry;
    logic [15:0] ld_val;
    logic ld_wide;
    logic [7:0] wr_mask;
    logic [7:0] wr_val;
  } cspf_cmd_s;
  // state shown back to the core
  typedef struct packed {
    logic [15:0] stack_pointer;
    logic [15:0] instruction_address_counter;
    logic [7:0] condition_flags;
    logic [7:0] alu_result;
  } cspf_view_s;
endpackage

// ===== hw/cspf_regs.sv
// stack pointer, instruction address counter and condition flag registers of an 8-bit core
// assumes one 125 MHz clock, a sequencer issuing cspf_cmd_s commands and a byte memory for the reset vector
`timescale 1ns/1ns

// What this block does
// - 16-bit stack pointer addresses next free slot
// - stack pointer resets to 0x00ff
// - stack adjust adds signed 8-bit immediate
// - stack low reset changes low byte only
// - calls push return address, interrupts also registers
// - 16-bit counter advances on every fetched byte not paired with a change of flow
// - change of flow loads target address
// - reset loads counter from top-of-memory vector
// - 8-bit flags, bits 6 and 5 one
// - overflow bit 7 on two's complement overflow
// - half carry bit 4 from bit 3 on add
// - decimal adjust corrects using half carry, carry
// - mask bit 3 blocks maskable interrupts
// - interrupt entry sets mask after stacking
// - no interrupt at boundary after mask clear
// - negative bit 2 follows result msb
// - zero bit 1 on all-zero 8/16-bit value
// - carry bit 0 on carry or borrow
module cspf_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // avalon-mm register slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // core command and state view
  input cspf_pkg::cspf_cmd_s cmd_i,
  output cspf_pkg::cspf_view_s view_o,
  // interrupt gating
  input wire logic irq_i,
  input wire logic boundary_i,
  output logic int_take_o,
  // reset vector fetch
  output logic [15:0] vec_addr_o,
  output logic vec_rd_o,
  input wire logic [7:0] vec_data_i,
  input wire logic vec_valid_i,
  output logic run_o
);
  import cspf_pkg::*;

  typedef enum logic [1:0] {CSPF_ST_VHI, CSPF_ST_VLO, CSPF_ST_RUN} cspf_state_e;

  logic [1:0] rst_sync_q;
  logic rst_n;
  cspf_state_e state_q, state_d;
  logic [15:0] sp_q, sp_d, pc_q, pc_d;
  logic [7:0] fl_q, fl_d, res_q, res_d;
  logic [7:0] vec_hi_q;
  logic shadow_q, shadow_d;
  logic ack_q;
  logic [31:0] rdata_q;

  // decimal correction value for a prior binary add
  function automatic logic [7:0] cspf_bcd_corr(input logic [7:0] a, input logic h, input logic c);
    cspf_bcd_corr = ((h || (a[3:0] > CSPF_BCD_DIG_MAX)) ? CSPF_BCD_CORR_LO : 8'h00) |
                    ((c || (a > CSPF_BCD_BYTE_MAX)) ? CSPF_BCD_CORR_HI : 8'h00);
  endfunction

  // two-flop release keeps reset removal clean against clk_i
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // bus decode, one wait state then a one-cycle answer
  wire bus_req = read || write;
  wire bus_wr = write && ack_q;
  wire wr_sp = bus_wr && (address == CSPF_OFS_SP);
  wire wr_pc = bus_wr && (address == CSPF_OFS_PC);
  wire wr_fl = bus_wr && (address == CSPF_OFS_FLAGS);
  assign waitrequest = bus_req && !ack_q;
  wire [31:0] rd_mux = (address == CSPF_OFS_SP) ? {16'h0000, sp_q} :
                       (address == CSPF_OFS_PC) ? {16'h0000, pc_q} :
                       (address == CSPF_OFS_FLAGS) ? {24'h000000, fl_q} :
                       (address == CSPF_OFS_STAT) ? {30'h0, shadow_q, run_o} : 32'h0;

  // arithmetic datapath shared by add, subtract and decimal adjust
  wire cin = cmd_i.use_carry && fl_q[CSPF_B_C];
  wire [8:0] add_sum = {1'b0, cmd_i.opa} + {1'b0, cmd_i.opb} + {8'h00, cin};
  wire [4:0] add_nib = {1'b0, cmd_i.opa[3:0]} + {1'b0, cmd_i.opb[3:0]} + {4'h0, cin};
  wire [8:0] sub_dif = {1'b0, cmd_i.opa} - {1'b0, cmd_i.opb} - {8'h00, cin};
  wire [7:0] daa_corr = cspf_bcd_corr(cmd_i.opa, fl_q[CSPF_B_H], fl_q[CSPF_B_C]);
  wire [7:0] daa_res = cmd_i.opa + daa_corr;
  wire daa_c = fl_q[CSPF_B_C] || (cmd_i.opa > CSPF_BCD_BYTE_MAX);
  wire add_v = (cmd_i.opa[7] == cmd_i.opb[7]) && (add_sum[7] != cmd_i.opa[7]);
  wire sub_v = (cmd_i.opa[7] != cmd_i.opb[7]) && (sub_dif[7] != cmd_i.opa[7]);
  wire [7:0] sp_imm = cmd_i.sp_val[7:0];
  wire running = (state_q == CSPF_ST_RUN);
  wire do_fl = running && (cmd_i.fl_op != CSPF_FL_NONE);
  wire do_sp = running && (cmd_i.sp_op != CSPF_SP_NONE);

  // stack pointer next value, core operation before software write
  always_comb begin
    sp_d = sp_q;
    if (do_sp) begin
      case (cmd_i.sp_op)
        CSPF_SP_PUSH: sp_d = sp_q - 16'h0001;
        CSPF_SP_PULL: sp_d = sp_q + 16'h0001;
        CSPF_SP_ADJ: sp_d = sp_q + {{8{sp_imm[7]}}, sp_imm};
        CSPF_SP_LOWRST: sp_d = {sp_q[15:8], CSPF_SP_LOW_RST};
        CSPF_SP_LOAD: sp_d = cmd_i.sp_val;
        default: sp_d = sp_q;
      endcase
    end else if (wr_sp) begin
      sp_d = writedata[15:0];
    end
  end

  // counter: vector load out of reset, then fetch advance or change of flow
  always_comb begin
    pc_d = pc_q;
    state_d = state_q;
    case (state_q)
      CSPF_ST_VHI: begin
        if (vec_valid_i) state_d = CSPF_ST_VLO;
      end
      CSPF_ST_VLO: begin
        if (vec_valid_i) begin
          pc_d = {vec_hi_q, vec_data_i};
          state_d = CSPF_ST_RUN;
        end
      end
      CSPF_ST_RUN: begin
        if (cmd_i.pc_load) pc_d = cmd_i.pc_target;
        else if (cmd_i.fetch) pc_d = pc_q + 16'h0001;
        else if (wr_pc) pc_d = writedata[15:0];
      end
      default: state_d = CSPF_ST_VHI;
    endcase
  end

  // flag update; bits outside an operation's reach are left as they were
  always_comb begin
    fl_d = fl_q;
    res_d = res_q;
    case (do_fl ? cmd_i.fl_op : CSPF_FL_NONE)
      CSPF_FL_ADD: begin
        res_d = add_sum[7:0];
        fl_d[CSPF_B_V] = add_v;
        fl_d[CSPF_B_H] = add_nib[4];
        fl_d[CSPF_B_N] = add_sum[7];
        fl_d[CSPF_B_Z] = (add_sum[7:0] == 8'h00);
        fl_d[CSPF_B_C] = add_sum[8];
      end
      CSPF_FL_SUB: begin
        res_d = sub_dif[7:0];
        fl_d[CSPF_B_V] = sub_v;
        fl_d[CSPF_B_N] = sub_dif[7];
        fl_d[CSPF_B_Z] = (sub_dif[7:0] == 8'h00);
        fl_d[CSPF_B_C] = sub_dif[8];
      end
      CSPF_FL_LDST: begin
        fl_d[CSPF_B_V] = 1'b0;
        fl_d[CSPF_B_N] = cmd_i.ld_wide ? cmd_i.ld_val[15] : cmd_i.ld_val[7];
        fl_d[CSPF_B_Z] = cmd_i.ld_wide ? (cmd_i.ld_val == 16'h0000) : (cmd_i.ld_val[7:0] == 8'h00);
      end
      CSPF_FL_DAA: begin
        res_d = daa_res;
        fl_d[CSPF_B_N] = daa_res[7];
        fl_d[CSPF_B_Z] = (daa_res == 8'h00);
        fl_d[CSPF_B_C] = daa_c;
      end
      CSPF_FL_WR: fl_d = (fl_q & ~cmd_i.wr_mask) | (cmd_i.wr_val & cmd_i.wr_mask);
      CSPF_FL_MCLR: fl_d[CSPF_B_I] = 1'b0;
      CSPF_FL_IENT: fl_d[CSPF_B_I] = 1'b1;
      default: if (wr_fl) fl_d = writedata[7:0];
    endcase
    fl_d = fl_d | CSPF_FLAGS_ONES;
  end

  // a falling mask arms the shadow; the next boundary consumes it
  wire mask_falls = fl_q[CSPF_B_I] && !fl_d[CSPF_B_I];
  assign shadow_d = mask_falls ? 1'b1 : (boundary_i ? 1'b0 : shadow_q);
  assign int_take_o = running && boundary_i && irq_i && !fl_q[CSPF_B_I] && !shadow_q;

  // architectural registers
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sp_q <= CSPF_SP_RST;
      pc_q <= 16'h0000;
      fl_q <= CSPF_FLAGS_RST;
      res_q <= 8'h00;
      shadow_q <= 1'b0;
      state_q <= CSPF_ST_VHI;
    end else begin
      sp_q <= sp_d;
      pc_q <= pc_d;
      fl_q <= fl_d;
      res_q <= res_d;
      shadow_q <= shadow_d;
      state_q <= state_d;
    end
  end

  // high vector byte and bus answer
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      vec_hi_q <= 8'h00;
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      if (state_q == CSPF_ST_VHI && vec_valid_i) vec_hi_q <= vec_data_i;
      ack_q <= bus_req && !ack_q;
      if (read && !ack_q) rdata_q <= rd_mux;
    end
  end

  assign readdata = rdata_q;
  assign vec_rd_o = !running;
  assign vec_addr_o = (state_q == CSPF_ST_VLO) ? CSPF_VEC_LO_ADDR : CSPF_VEC_HI_ADDR;
  assign run_o = running;
  assign view_o = '{stack_pointer: sp_q, instruction_address_counter: pc_q, condition_flags: fl_q, alu_result: res_q};

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence vec_hi_s;
    state_q == CSPF_ST_VHI && vec_valid_i;
  endsequence
  sequence vec_lo_s;
    state_q == CSPF_ST_VLO && vec_valid_i;
  endsequence

  sp_reset_value_a: assert property ($rose(rst_n) |-> sp_q == 16'h00ff) else $error("sp not 00ff after reset");
  // the two vector bytes may arrive with idle cycles between them, so only the low byte closes the load
  vector_load_a: assert property (vec_lo_s |=> run_o && pc_q == {$past(vec_hi_q), $past(vec_data_i)})
    else $error("vector not loaded");
  fetch_advance_a: assert property (running && cmd_i.fetch && !cmd_i.pc_load |=> pc_q == $past(pc_q) + 16'h0001)
    else $error("counter did not advance");
  flow_load_a: assert property (running && cmd_i.pc_load |=> pc_q == $past(cmd_i.pc_target))
    else $error("target not loaded");
  stack_adjust_a: assert property (do_sp && cmd_i.sp_op == CSPF_SP_ADJ |=>
    sp_q == $past(sp_q) + {{8{$past(sp_imm[7])}}, $past(sp_imm)}) else $error("adjust wrong");
  low_reset_a: assert property (do_sp && cmd_i.sp_op == CSPF_SP_LOWRST |=> sp_q == {$past(sp_q[15:8]), 8'hff})
    else $error("low reset wrong");
  fixed_ones_a: assert property (fl_q[6:5] == 2'b11) else $error("fixed flag bits not one");
  int_shadow_a: assert property (mask_falls |=> shadow_q) else $error("shadow not armed");
  mask_blocks_a: assert property (fl_q[CSPF_B_I] |-> !int_take_o) else $error("masked interrupt taken");
  entry_mask_a: assert property (do_fl && cmd_i.fl_op == CSPF_FL_IENT |=> fl_q[CSPF_B_I]) else $error("mask not set");
  add_carry_a: assert property (do_fl && cmd_i.fl_op == CSPF_FL_ADD |=>
    fl_q[CSPF_B_C] == $past(add_sum[8]) && fl_q[CSPF_B_H] == $past(add_nib[4])) else $error("add carries wrong");
  flags_hold_a: assert property (running && cmd_i.fl_op == CSPF_FL_NONE && !wr_fl |=> $stable(fl_q))
    else $error("flags changed idle");

  // stack moves by one byte per push or pull, so the pointer always names the next free slot
  push_dec_a: assert property (do_sp && cmd_i.sp_op == CSPF_SP_PUSH |=> sp_q == $past(sp_q) - 16'h0001)
    else $error("push did not decrement");
  pull_inc_a: assert property (do_sp && cmd_i.sp_op == CSPF_SP_PULL |=> sp_q == $past(sp_q) + 16'h0001)
    else $error("pull did not increment");

  // subtract flags: borrow lands in carry, overflow on a sign flip of unlike operands
  sub_flags_a: assert property (do_fl && cmd_i.fl_op == CSPF_FL_SUB |=>
    fl_q[CSPF_B_C] == $past(sub_dif[8]) && fl_q[CSPF_B_V] == $past(sub_v)) else $error("subtract flags wrong");

  // n and z are checked against the stored result, not the adder, to catch a mixed-up copy
  add_nz_a: assert property (do_fl && cmd_i.fl_op == CSPF_FL_ADD |=>
    fl_q[CSPF_B_N] == res_q[7] && fl_q[CSPF_B_Z] == (res_q == 8'h00)) else $error("add n or z wrong");
  load_neg_a: assert property (do_fl && cmd_i.fl_op == CSPF_FL_LDST |=>
    fl_q[CSPF_B_N] == $past(cmd_i.ld_wide ? cmd_i.ld_val[15] : cmd_i.ld_val[7])) else $error("load n wrong");
  load_zero_a: assert property (do_fl && cmd_i.fl_op == CSPF_FL_LDST && cmd_i.ld_wide |=>
    fl_q[CSPF_B_Z] == ($past(cmd_i.ld_val) == 16'h0000)) else $error("wide load z wrong");

  // decimal adjust keeps a carry once set, since the byte already overflowed the decimal range
  daa_carry_a: assert property (do_fl && cmd_i.fl_op == CSPF_FL_DAA |=>
    fl_q[CSPF_B_C] == ($past(fl_q[CSPF_B_C]) || ($past(cmd_i.opa) > CSPF_BCD_BYTE_MAX)))
    else $error("decimal carry wrong");

  // an unmasked request outside the shadow must be accepted at the boundary
  int_accept_a: assert property (running && boundary_i && irq_i && !fl_q[CSPF_B_I] && !shadow_q |-> int_take_o)
    else $error("open interrupt not taken");
endmodule // cspf_regs

// ===== verification/cspf_regs_bench.sv
// self-checking bench for the stack pointer, instruction address counter and condition flag registers
// assumes the design's avalon-mm slave answers with one wait state and takes core commands only after run_o
`timescale 1ns/1ns
module cspf_regs_bench;
  import cspf_pkg::*;
  logic clk_i, resetn_i, read, write, irq_i, boundary_i, vec_valid_i;
  logic [3:0] address;
  logic [31:0] writedata, readdata, rd;
  logic waitrequest, int_take_o, vec_rd_o, run_o;
  logic [15:0] vec_addr_o, sp, pc;
  logic [7:0] vec_data_i, fl;
  cspf_cmd_s cmd_i, c;
  cspf_view_s view_o;
  int error_cnt = 0;
  int tests_run = 0;
  cspf_regs cspf_regs_inst (.clk_i(clk_i), .resetn_i(resetn_i), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .cmd_i(cmd_i), .view_o(view_o),
    .irq_i(irq_i), .boundary_i(boundary_i), .int_take_o(int_take_o), .vec_addr_o(vec_addr_o),
    .vec_rd_o(vec_rd_o), .vec_data_i(vec_data_i), .vec_valid_i(vec_valid_i), .run_o(run_o));
  // 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // avalon transfer: hold the request until waitrequest is sampled low, then release
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do @(posedge clk_i); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // one core command for one cycle, view sampled once it has settled
  task automatic cmd(input cspf_cmd_s k);
    @(posedge clk_i);
    cmd_i <= k;
    @(posedge clk_i);
    cmd_i <= '0;
    @(negedge clk_i);
  endtask
  task automatic bnd(input logic exp);
    @(posedge clk_i);
    boundary_i <= 1'b1;
    @(negedge clk_i);
    chk("int_take", int_take_o, exp);
    @(posedge clk_i);
    boundary_i <= 1'b0;
  endtask
  // expected flags of an add or subtract, from the previous bench copy of the flags
  function automatic logic [7:0] fexp(input logic [7:0] f, input logic [7:0] a, input logic [7:0] b, input logic s);
    logic [8:0] r;
    r = s ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
    f[7] = (s ? (a[7] != b[7]) : (a[7] == b[7])) && (r[7] != a[7]);
    if (!s) f[4] = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f;
    f[2] = r[7];
    f[1] = (r[7:0] == 8'h00);
    f[0] = r[8];
    return f;
  endfunction
  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #200000;
    error_cnt++;
    test_done();
  end
  initial begin
    logic [7:0] ta[5] = '{8'h08, 8'h7f, 8'hff, 8'h80, 8'h00};
    logic [7:0] tb[5] = '{8'h08, 8'h01, 8'h01, 8'h01, 8'h01};
    resetn_i = 1'b0; read = 1'b0; write = 1'b0; address = 4'h0; writedata = '0; cmd_i = '0;
    irq_i = 1'b1; boundary_i = 1'b0; vec_valid_i = 1'b0; vec_data_i = 8'h00;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    bus(1'b0, CSPF_OFS_SP, '0); chk("sp reset", rd, 32'h0000_00ff);
    bus(1'b0, CSPF_OFS_FLAGS, '0); chk("flags reset", rd, 32'h0000_0068);
    bus(1'b0, 4'h2, '0); chk("unmapped", rd, 32'h0);
    chk("vec hi addr", vec_addr_o, 16'hfffe);
    chk("vec rd", vec_rd_o, 1'b1);
    @(posedge clk_i); vec_valid_i <= 1'b1; vec_data_i <= 8'hff;
    @(posedge clk_i); vec_valid_i <= 1'b0;
    @(negedge clk_i); chk("vec lo addr", vec_addr_o, 16'hffff);
    @(posedge clk_i); vec_valid_i <= 1'b1; vec_data_i <= 8'hfd;
    @(posedge clk_i); vec_valid_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("run", run_o, 1'b1);
    chk("vec rd done", vec_rd_o, 1'b0);
    pc = 16'hfffd; chk("pc vector", view_o.instruction_address_counter, pc);
    $display("test reset done");
    // back-to-back fetches across the top of the address space
    c = '0; c.fetch = 1'b1;
    @(posedge clk_i); cmd_i <= c;
    repeat (4) @(posedge clk_i);
    cmd_i <= '0;
    @(negedge clk_i); chk("pc fetch", view_o.instruction_address_counter, 16'h0001);
    c.pc_load = 1'b1; c.pc_target = 16'hc000;
    cmd(c); chk("pc load", view_o.instruction_address_counter, 16'hc000);
    bus(1'b0, CSPF_OFS_PC, '0); chk("pc bus", rd, 32'h0000_c000);
    $display("test counter done");
    sp = 16'h00ff;
    c = '0; c.sp_op = CSPF_SP_PUSH; cmd(c); chk("sp push", view_o.stack_pointer, sp - 16'h1);
    c.sp_op = CSPF_SP_PULL; cmd(c); chk("sp pull", view_o.stack_pointer, sp);
    c.sp_op = CSPF_SP_LOAD; c.sp_val = 16'h1234; cmd(c); chk("sp load", view_o.stack_pointer, 16'h1234);
    c.sp_op = CSPF_SP_ADJ; c.sp_val = 16'hfff0; cmd(c); chk("sp adj neg", view_o.stack_pointer, 16'h1224);
    c.sp_val = 16'h007f; cmd(c); chk("sp adj pos", view_o.stack_pointer, 16'h12a3);
    c.sp_op = CSPF_SP_LOWRST; cmd(c); chk("sp low", view_o.stack_pointer, 16'h12ff);
    bus(1'b1, CSPF_OFS_SP, 32'h0000_abcd);
    bus(1'b0, CSPF_OFS_SP, '0); chk("sp bus", rd, 32'h0000_abcd);
    $display("test stack done");
    fl = 8'h68;
    for (int i = 0; i < 10; i++) begin
      c = '0; c.fl_op = (i < 5) ? CSPF_FL_ADD : CSPF_FL_SUB; c.opa = ta[i % 5]; c.opb = tb[i % 5];
      cmd(c); fl = fexp(fl, ta[i % 5], tb[i % 5], i >= 5);
      chk("flags arith", view_o.condition_flags, fl);
    end
    c = '0; c.fl_op = CSPF_FL_LDST; c.ld_val = 16'h0000; c.ld_wide = 1'b1; cmd(c);
    fl[7] = 1'b0; fl[2] = 1'b0; fl[1] = 1'b1;
    chk("flags load zero", view_o.condition_flags, fl);
    c.ld_val = 16'h0080; c.ld_wide = 1'b0; cmd(c); fl[2] = 1'b1; fl[1] = 1'b0;
    chk("flags load neg", view_o.condition_flags, fl);
    c = '0; c.fl_op = CSPF_FL_ADD; c.opa = 8'h19; c.opb = 8'h28; cmd(c); fl = fexp(fl, 8'h19, 8'h28, 1'b0);
    c.fl_op = CSPF_FL_DAA; c.opa = 8'h41; cmd(c);
    chk("daa result", view_o.alu_result, 8'h47);
    chk("daa carry", view_o.condition_flags[CSPF_B_C], 1'b0);
    $display("test flags done");
    bnd(1'b0);
    c = '0; c.fl_op = CSPF_FL_MCLR; cmd(c);
    chk("mask clear", view_o.condition_flags[CSPF_B_I], 1'b0);
    bnd(1'b0);
    bnd(1'b1);
    c.sp_op = CSPF_SP_PUSH; c.fl_op = CSPF_FL_NONE; cmd(c);
    c.sp_op = CSPF_SP_NONE; c.fl_op = CSPF_FL_IENT; cmd(c);
    chk("mask entry", view_o.condition_flags[CSPF_B_I], 1'b1);
    bnd(1'b0);
    bus(1'b1, CSPF_OFS_FLAGS, 32'h0000_0000);
    bus(1'b0, CSPF_OFS_FLAGS, '0); chk("flags ones", rd, 32'h0000_0060);
    bus(1'b0, CSPF_OFS_STAT, '0); chk("shadow armed", rd, 32'h0000_0003);
    c = '0; c.fl_op = CSPF_FL_WR; c.wr_mask = 8'h09; c.wr_val = 8'h01; cmd(c);
    chk("flags partial", view_o.condition_flags, 8'h61);
    c = '0; c.fl_op = CSPF_FL_ADD; c.opa = 8'h01; c.opb = 8'h01; c.use_carry = 1'b1; cmd(c);
    chk("adc result", view_o.alu_result, 8'h03);
    chk("adc flags", view_o.condition_flags, 8'h60);
    $display("test mask done");
    test_done();
  end
endmodule // cspf_regs_bench
